// *** core/pmwe_params.svh ***
// ==========================================================================
// Function
// - reset leaves power mode at normal
// - mode 01 selects energy detect
// - no energy past go-sleep time: low power
// - energy past wake-up time wakes when auto-wakeup is set
// - auto-wakeup picks normal state or normal mode
// - low power gates all but energy detect
// - energy event drives power event output
// - energy event interrupt when enabled
// - wake register read leaves low power when auto-wakeup is clear
// - mode 10 is soft power down
// - only wake register read exits power down
// - power saving needs autoneg, no cable, bit10
// - power saving gates only unused receive block
// - power-down pin off, rising edge resets chip
// - wake frames report via interrupt or event
// - energy wake sets status bit 2
// - link-up sets status bit 3
// - pattern frame bit 4, wake frame bit 5
// - four wake frames enabled by bits 0-3
// - bit 7 enables pattern frame scanning
// - six ff then sixteen node addresses
// - pattern frame needs good crc and address
`ifndef PMWE_PARAMS_SVH
`define PMWE_PARAMS_SVH
`define PMWE_OFF_GLOBAL_RESET_WAKE 8'h26
`define PMWE_OFF_WAKE_FRAME_CTRL   8'h2a
`define PMWE_OFF_WAKE_FRAME0       8'h30
`define PMWE_OFF_WAKE_FRAME_STEP   8'h10
`define PMWE_OFF_INT_ENABLE        8'h90
`define PMWE_OFF_INT_STATUS        8'h92
`define PMWE_OFF_PM_CTRL           8'hd4
`define PMWE_OFF_SLEEP_WAKE_TIMER  8'hd6
`define PMWE_OFF_PORT_CTRL         8'hf6
`define PMWE_MODE_NORMAL   2'h0
`define PMWE_MODE_ENERGY   2'h1
`define PMWE_MODE_SOFT_PD  2'h2
`define PMWE_MODE_SAVING   2'h3
`define PMWE_PM_WAKE_NORMAL 6
`define PMWE_PM_AUTO_WAKE   7
`define PMWE_PM_EVENT_EN    8
`define PMWE_INT_ENERGY     2
`define PMWE_INT_LINKUP     3
`define PMWE_INT_PATTERN    4
`define PMWE_INT_WAKEFRAME  5
`define PMWE_WF_PATTERN_EN  7
`define PMWE_PORT_SAVING    10
`define PMWE_SYNC_BYTES     3'h6
`define PMWE_ADDR_COPIES    5'h10
`define PMWE_ADDR_LAST      3'h5
`define PMWE_TICK_US        10
`define PMWE_CLK_MHZ        200
`define PMWE_TICK_CYCLES    (`PMWE_TICK_US * `PMWE_CLK_MHZ)
`define PMWE_RST_PM_CTRL    16'h0000
`define PMWE_RST_TIMER      16'h0000
`define PMWE_RST_ZERO16     16'h0000
`endif

// *** core/pmwe_pkg.sv ***
package pmwe_pkg;
    typedef enum logic [2:0] {
        PMWE_NORMAL  = 3'b000,
        PMWE_AWAKE   = 3'b001,
        PMWE_LOWPWR  = 3'b011,
        PMWE_SOFT_PD = 3'b010,
        PMWE_SAVING  = 3'b110
    } pmwe_state_e;
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } pmwe_bus_s;
    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       eof;
        logic       crc_ok;
        logic       da_ok;
        logic [7:0] data;
    } pmwe_rx_s;
    typedef struct packed {
        logic pll_en;
        logic phy_en;
        logic phy_rx_unused_off;
        logic energy_det_en;
        logic mac_en;
        logic host_en;
    } pmwe_gate_s;
endpackage

// *** core/pmwe_unit.sv ***
`timescale 1ns/1ps
`include "pmwe_params.svh"
module pmwe_unit (
    // clock and reset
    input  wire  logic                 sys_clk,
    input  wire  logic                 reset_n,
    // register port
    input  wire  pmwe_pkg::pmwe_bus_s  bus,
    output logic [15:0]                rdata,
    // line status
    input  wire  logic                 energy_present,
    input  wire  logic                 link_up,
    input  wire  logic                 autoneg_en,
    input  wire  logic [47:0]          node_addr,
    input  wire  logic [1:0]           frame_crc_hit,
    input  wire  pmwe_pkg::pmwe_rx_s   rx,
    input  wire  logic [15:0]          rx_frame_crc,
    // power-down pin
    input  wire  logic                 chip_power_down_pin_n,
    // outputs
    output pmwe_pkg::pmwe_gate_s       gate,
    output logic                       chip_reset_n,
    output logic                       interrupt_output_low_n,
    output logic                       power_event_output
);
    import pmwe_pkg::*;

    // ======================================================================
    // registers
    logic [15:0] pm_ctrl_q, timer_q, int_en_q, int_stat_q, wf_ctrl_q, port_q;
    logic [15:0] wf_crc_q [4];
    logic        pin_q, pwr_rst_q;
    pmwe_state_e state_q;
    logic        energy_evt, link_evt, pattern_evt, frame_evt, wake_rd, wake_to_mode;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign wake_rd = bus.rd && hit(bus.addr, `PMWE_OFF_GLOBAL_RESET_WAKE);

    // ======================================================================
    // power-down pin: low holds chip off, rising edge resets registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_q     <= 1'b1;
            pwr_rst_q <= 1'b0;
        end else begin
            pin_q     <= chip_power_down_pin_n;
            pwr_rst_q <= chip_power_down_pin_n && !pin_q;
        end
    end
    // pin_q term keeps the reset low across the rising edge, no release glitch
    assign chip_reset_n = chip_power_down_pin_n && pin_q && !pwr_rst_q;

    // ======================================================================
    // register writes; power saving mode keeps them accessible
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pm_ctrl_q <= `PMWE_RST_PM_CTRL;
            timer_q   <= `PMWE_RST_TIMER;
            int_en_q  <= `PMWE_RST_ZERO16;
            wf_ctrl_q <= `PMWE_RST_ZERO16;
            port_q    <= `PMWE_RST_ZERO16;
            for (int i = 0; i < 4; i++) begin
                wf_crc_q[i] <= `PMWE_RST_ZERO16;
            end
        end else if (pwr_rst_q) begin
            pm_ctrl_q <= `PMWE_RST_PM_CTRL;
            timer_q   <= `PMWE_RST_TIMER;
            int_en_q  <= `PMWE_RST_ZERO16;
            wf_ctrl_q <= `PMWE_RST_ZERO16;
            port_q    <= `PMWE_RST_ZERO16;
            for (int i = 0; i < 4; i++) begin
                wf_crc_q[i] <= `PMWE_RST_ZERO16;
            end
        end else begin
            if (bus.wr && gate.host_en) begin
                if (hit(bus.addr, `PMWE_OFF_PM_CTRL)) begin
                    pm_ctrl_q <= bus.wdata;
                end
                if (hit(bus.addr, `PMWE_OFF_SLEEP_WAKE_TIMER)) begin
                    timer_q <= bus.wdata;
                end
                if (hit(bus.addr, `PMWE_OFF_INT_ENABLE)) begin
                    int_en_q <= bus.wdata;
                end
                if (hit(bus.addr, `PMWE_OFF_WAKE_FRAME_CTRL)) begin
                    wf_ctrl_q <= bus.wdata;
                end
                if (hit(bus.addr, `PMWE_OFF_PORT_CTRL)) begin
                    port_q <= bus.wdata;
                end
                for (int i = 0; i < 4; i++) begin
                    if (hit(bus.addr, 8'(`PMWE_OFF_WAKE_FRAME0 + i * `PMWE_OFF_WAKE_FRAME_STEP))) begin
                        wf_crc_q[i] <= bus.wdata;
                    end
                end
            end
            // waking into normal operation mode also clears the mode field
            if ((state_q == PMWE_SOFT_PD && wake_rd) || wake_to_mode) begin
                pm_ctrl_q[1:0] <= `PMWE_MODE_NORMAL;
            end
        end
    end

    // ======================================================================
    // slow tick and energy timers
    logic [15:0] tick_cnt_q;
    logic        tick;
    logic [7:0]  tmr_q;
    logic        energy_q, sleep_due, wake_due;

    assign tick = (tick_cnt_q == 16'(`PMWE_TICK_CYCLES - 1));

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_q <= 16'h0000;
        end else begin
            tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
        end
    end

    // one counter serves both timers; it restarts when energy changes
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            energy_q <= 1'b0;
            tmr_q    <= 8'h00;
        end else begin
            energy_q <= energy_present;
            if (energy_present != energy_q || state_q == PMWE_NORMAL) begin
                tmr_q <= 8'h00;
            end else if (tick && tmr_q != 8'hff) begin
                tmr_q <= tmr_q + 8'h01;
            end
        end
    end

    assign sleep_due = !energy_q && !energy_present && tmr_q > timer_q[7:0];
    assign wake_due  = energy_q && energy_present && tmr_q > timer_q[15:8];
    assign wake_to_mode = state_q == PMWE_LOWPWR && wake_due
                          && pm_ctrl_q[`PMWE_PM_AUTO_WAKE] && pm_ctrl_q[`PMWE_PM_WAKE_NORMAL];

    // ======================================================================
    // power mode sequencer
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= PMWE_NORMAL;
        end else if (pwr_rst_q) begin
            state_q <= PMWE_NORMAL;
        end else begin
            unique case (state_q)
                PMWE_NORMAL: begin
                    unique case (pm_ctrl_q[1:0])
                        `PMWE_MODE_ENERGY: state_q <= PMWE_AWAKE;
                        `PMWE_MODE_SOFT_PD: state_q <= PMWE_SOFT_PD;
                        `PMWE_MODE_SAVING: begin
                            if (autoneg_en && !link_up && port_q[`PMWE_PORT_SAVING]) begin
                                state_q <= PMWE_SAVING;
                            end
                        end
                        default: state_q <= PMWE_NORMAL;
                    endcase
                end
                PMWE_AWAKE: begin
                    if (pm_ctrl_q[1:0] != `PMWE_MODE_ENERGY) begin
                        state_q <= PMWE_NORMAL;
                    end else if (sleep_due) begin
                        state_q <= PMWE_LOWPWR;
                    end
                end
                PMWE_LOWPWR: begin
                    if (wake_to_mode) begin
                        state_q <= PMWE_NORMAL;
                    end else if (wake_due && pm_ctrl_q[`PMWE_PM_AUTO_WAKE]) begin
                        state_q <= PMWE_AWAKE;
                    end else if (wake_rd && !pm_ctrl_q[`PMWE_PM_AUTO_WAKE]) begin
                        state_q <= PMWE_AWAKE;
                    end
                end
                PMWE_SOFT_PD: begin
                    if (wake_rd) begin
                        state_q <= PMWE_NORMAL;
                    end
                end
                PMWE_SAVING: begin
                    if (pm_ctrl_q[1:0] != `PMWE_MODE_SAVING || !port_q[`PMWE_PORT_SAVING]) begin
                        state_q <= PMWE_NORMAL;
                    end
                end
            endcase
        end
    end

    // ======================================================================
    // block gating
    always_comb begin
        gate = '{default: 1'b1};
        gate.phy_rx_unused_off = 1'b0;
        if (!chip_power_down_pin_n) begin
            gate = '0;
        end else begin
            unique case (state_q)
                PMWE_LOWPWR: begin
                    gate = '0;
                    gate.energy_det_en = 1'b1;
                end
                PMWE_SOFT_PD: gate = '0;
                PMWE_SAVING: gate.phy_rx_unused_off = !link_up && !energy_present;
                default: ;
            endcase
        end
    end

    // ======================================================================
    // remote-wake pattern scanner: sync run then sixteen address copies
    logic [2:0] ff_run_q, byte_q;
    logic [4:0] copy_q;
    logic       seq_ok_q;
    logic [7:0] addr_byte;

    function automatic logic [7:0] addr_at(input logic [47:0] a, input logic [2:0] i);
        addr_at = a[8'(47 - 8 * i) -: 8];
    endfunction

    assign addr_byte = addr_at(node_addr, byte_q);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ff_run_q <= 3'h0;
            byte_q   <= 3'h0;
            copy_q   <= 5'h00;
            seq_ok_q <= 1'b0;
        end else if (rx.valid && rx.sof) begin
            ff_run_q <= 3'h0;
            byte_q   <= 3'h0;
            copy_q   <= 5'h00;
            seq_ok_q <= 1'b0;
        end else if (rx.valid && wf_ctrl_q[`PMWE_WF_PATTERN_EN] && !seq_ok_q) begin
            if (ff_run_q == `PMWE_SYNC_BYTES && rx.data == addr_byte) begin
                // extra ff bytes before the first copy keep the sync alive
                if (byte_q == `PMWE_ADDR_LAST) begin
                    byte_q <= 3'h0;
                    copy_q <= copy_q + 5'h01;
                    if (copy_q == `PMWE_ADDR_COPIES - 5'h01) begin
                        seq_ok_q <= 1'b1;
                    end
                end else begin
                    byte_q <= byte_q + 3'h1;
                end
            end else if (rx.data == 8'hff) begin
                byte_q   <= 3'h0;
                copy_q   <= 5'h00;
                // an ff inside a broken copy run starts a fresh sync count
                if (byte_q != 3'h0 || copy_q != 5'h00) begin
                    ff_run_q <= 3'h1;
                end else begin
                    ff_run_q <= (ff_run_q == `PMWE_SYNC_BYTES) ? ff_run_q : ff_run_q + 3'h1;
                end
            end else begin
                ff_run_q <= 3'h0;
                byte_q   <= 3'h0;
                copy_q   <= 5'h00;
            end
        end
    end

    assign pattern_evt = rx.valid && rx.eof && seq_ok_q && rx.crc_ok && rx.da_ok;

    // ======================================================================
    // wake frames: per-frame crc compare at end of frame
    always_comb begin
        frame_evt = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (wf_ctrl_q[i] && rx_frame_crc == wf_crc_q[i]) begin
                frame_evt = rx.valid && rx.eof && rx.crc_ok && rx.da_ok;
            end
        end
    end

    // ======================================================================
    // sticky status and event outputs
    logic link_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            link_q <= 1'b0;
        end else begin
            link_q <= link_up;
        end
    end

    assign energy_evt = state_q == PMWE_LOWPWR && wake_due;
    assign link_evt   = link_up && !link_q;

    logic [15:0] set_v, clr_v;
    always_comb begin
        set_v = '0;
        set_v[`PMWE_INT_ENERGY]    = energy_evt;
        set_v[`PMWE_INT_LINKUP]    = link_evt;
        set_v[`PMWE_INT_PATTERN]   = pattern_evt;
        set_v[`PMWE_INT_WAKEFRAME] = frame_evt;
        clr_v = (bus.wr && gate.host_en && hit(bus.addr, `PMWE_OFF_INT_STATUS)) ? bus.wdata : '0;
    end

    // write one to clear; a set in the same cycle wins
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            int_stat_q <= `PMWE_RST_ZERO16;
        end else if (pwr_rst_q) begin
            int_stat_q <= `PMWE_RST_ZERO16;
        end else begin
            int_stat_q <= (int_stat_q & ~clr_v) | set_v;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            interrupt_output_low_n <= 1'b1;
            power_event_output     <= 1'b0;
        end else begin
            interrupt_output_low_n <= !(|(int_stat_q & int_en_q));
            power_event_output     <= pm_ctrl_q[`PMWE_PM_EVENT_EN]
                                      && |(int_stat_q & 16'h003c);
        end
    end

    // ======================================================================
    // read data; unmapped reads give zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 16'h0000;
        end else if (bus.rd) begin
            unique case (bus.addr)
                `PMWE_OFF_PM_CTRL:          rdata <= pm_ctrl_q;
                `PMWE_OFF_SLEEP_WAKE_TIMER: rdata <= timer_q;
                `PMWE_OFF_INT_ENABLE:       rdata <= int_en_q;
                `PMWE_OFF_INT_STATUS:       rdata <= int_stat_q;
                `PMWE_OFF_WAKE_FRAME_CTRL:  rdata <= wf_ctrl_q;
                `PMWE_OFF_PORT_CTRL:        rdata <= port_q;
                default:                    rdata <= 16'h0000;
            endcase
        end
    end
endmodule

// *** verification/pmwe_unit_sva.sv ***
`timescale 1ns/1ps
module pmwe_unit_sva (
    // clock and reset
    input wire logic                 sys_clk,
    input wire logic                 reset_n,
    // watched ports
    input wire pmwe_pkg::pmwe_bus_s  bus,
    input wire pmwe_pkg::pmwe_gate_s gate,
    input wire logic                 chip_power_down_pin_n,
    input wire logic                 chip_reset_n,
    input wire logic                 interrupt_output_low_n,
    input wire logic                 power_event_output
);
    import pmwe_pkg::*;
    // =======================================
    // helpers
    logic       up;
    logic       soft_pd;
    logic       steady;
    logic [2:0] up_hist_q;
    assign up = chip_power_down_pin_n && chip_reset_n;
    assign soft_pd = up && !gate.pll_en && !gate.energy_det_en;
    // registers reset late after the pin rises, so sticky checks wait for a calm history
    assign steady = up && (&up_hist_q);
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            up_hist_q <= 3'h0;
        end else begin
            up_hist_q <= {up_hist_q[1:0], up};
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // =======================================
    // properties
    a_pin_holds_reset: assert property (!chip_power_down_pin_n |-> !chip_reset_n)
        else $error("chip reset released while power-down pin low");
    a_rise_resets: assert property ($rose(chip_power_down_pin_n) |-> !chip_reset_n ##[1:3] chip_reset_n)
        else $error("no bounded chip reset pulse after pin rise");
    a_lowpwr_gates: assert property (up && gate.energy_det_en && !gate.pll_en |->
        !gate.phy_en && !gate.mac_en && !gate.host_en)
        else $error("low power state left a block enabled");
    a_saving_gates: assert property (up && gate.phy_rx_unused_off |->
        gate.pll_en && gate.phy_en && gate.mac_en && gate.host_en)
        else $error("power saving gated more than the receive block");
    a_softpd_stays: assert property (soft_pd && !(bus.rd && bus.addr == 8'h26) |=> !gate.pll_en || !up)
        else $error("soft power down left without wake read");
    a_wake_read: assert property (soft_pd && bus.rd && bus.addr == 8'h26 |=> gate.pll_en && gate.mac_en)
        else $error("wake read did not restore normal operation");
    a_int_sticky: assert property (steady && !interrupt_output_low_n && !bus.wr && !$past(bus.wr) |=>
        !interrupt_output_low_n)
        else $error("interrupt dropped without a register write");
    a_event_sticky: assert property (steady && power_event_output && !bus.wr && !$past(bus.wr) |=>
        power_event_output)
        else $error("power event dropped without a register write");
endmodule
bind pmwe_unit pmwe_unit_sva pmwe_unit_sva_i (.sys_clk(sys_clk), .reset_n(reset_n), .bus(bus), .gate(gate),
    .chip_power_down_pin_n(chip_power_down_pin_n), .chip_reset_n(chip_reset_n),
    .interrupt_output_low_n(interrupt_output_low_n), .power_event_output(power_event_output));

// *** verification/pmwe_host_model.sv ***
`timescale 1ns/1ps
module pmwe_host_model (
    // clock and device outputs
    input wire logic            sys_clk,
    input wire logic            interrupt_output_low_n,
    input wire logic            power_event_output,
    // register port
    output pmwe_pkg::pmwe_bus_s bus,
    output logic                chk
);
    import pmwe_pkg::*;
    logic auto_wake;
    int   lat;
    initial begin
        bus = '0;
        chk = 1'b0;
        auto_wake = 1'b0;
        lat = 1;
    end
    // =======================================
    // bus cycles, idle fields scrambled so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        bus <= {2'b01, a, d};
        @(negedge sys_clk);
        bus <= {2'b00, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, input logic c);
        @(negedge sys_clk);
        bus <= {2'b10, a, 16'h0000};
        chk <= c;
        @(negedge sys_clk);
        bus <= {2'b00, ~a, 16'h5a5a};
        chk <= 1'b0;
    endtask
    // =======================================
    // power manager: on a wake report, after lat cycles, issue the wake read
    always @(negedge sys_clk) begin
        if (auto_wake && (!interrupt_output_low_n || power_event_output)) begin
            repeat (lat) @(negedge sys_clk);
            rd(8'h26, 1'b0);
            auto_wake = 1'b0;
        end
    end
endmodule

// *** verification/pmwe_unit_test.sv ***
`timescale 1ns/1ps
module pmwe_unit_test;
    import pmwe_pkg::*;
    logic        sys_clk, reset_n, energy_present, link_up, autoneg_en, chip_power_down_pin_n;
    logic        chip_reset_n, interrupt_output_low_n, power_event_output, chk, pend;
    logic [47:0] node_addr;
    logic [15:0] rdata, rx_frame_crc, crc, e;
    pmwe_bus_s   bus;
    pmwe_rx_s    rx;
    pmwe_gate_s  gate;
    logic [15:0] exp_q[$];
    int          bad_count = 0;
    int          total_checks = 0;
    pmwe_unit pmwe_unit_i (.sys_clk(sys_clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
        .energy_present(energy_present), .link_up(link_up), .autoneg_en(autoneg_en), .node_addr(node_addr),
        .frame_crc_hit(2'b00), .rx(rx), .rx_frame_crc(rx_frame_crc), .chip_power_down_pin_n(chip_power_down_pin_n),
        .gate(gate), .chip_reset_n(chip_reset_n), .interrupt_output_low_n(interrupt_output_low_n),
        .power_event_output(power_event_output));
    pmwe_host_model pmwe_host_model_i (.sys_clk(sys_clk), .interrupt_output_low_n(interrupt_output_low_n),
        .power_event_output(power_event_output), .bus(bus), .chk(chk));
    // =======================================
    // clock, watchdog, read monitor
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        #400000;
        bad_count++;
        $display("MISMATCH watchdog expected done seen hang");
        final_report;
    end
    always @(posedge sys_clk) pend <= chk;
    always @(negedge sys_clk) if (pend) check("rdata", exp_q.pop_front(), rdata);
    // =======================================
    // tasks
    task automatic check(input string what, input logic [15:0] x, input logic [15:0] s);
        total_checks++;
        if (s !== x) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, x, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        pmwe_host_model_i.wr(a, d);
    endtask
    task automatic rdx(input logic [7:0] a, input logic [15:0] x);
        exp_q.push_back(x);
        pmwe_host_model_i.rd(a, 1'b1);
    endtask
    task automatic gchk(input logic [5:0] x, input logic [5:0] m);
        repeat (2) @(negedge sys_clk);
        check("gate", 16'(x), 16'(gate & m));
    endtask
    task automatic pins(input logic i, input logic v);
        repeat (2) @(negedge sys_clk);
        check("int_n", 16'(i), 16'(interrupt_output_low_n));
        check("event", 16'(v), 16'(power_event_output));
    endtask
    // timers run in 2000-cycle ticks, so the bound covers a few ticks
    task automatic wt(input logic s, input logic v);
        int n;
        n = 0;
        while ((s ? interrupt_output_low_n : gate.pll_en) !== v && n < 20000) begin
            @(negedge sys_clk);
            n++;
        end
        check("wait", 16'(v), 16'(s ? interrupt_output_low_n : gate.pll_en));
    endtask
    task automatic frame(input int copies, input logic ok, input logic [15:0] c);
        logic [7:0] b[$];
        repeat (14) b.push_back(8'($urandom_range(0, 254)));
        repeat (6) b.push_back(8'hff);
        repeat (copies) for (int i = 5; i >= 0; i--) b.push_back(node_addr[i*8 +: 8]);
        repeat (4) b.push_back(8'h00);
        rx_frame_crc <= c;
        foreach (b[i]) begin
            @(negedge sys_clk);
            rx <= {1'b1, i == 0, i == b.size() - 1, ok, 1'b1, b[i]};
        end
        @(negedge sys_clk);
        rx <= '0;
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // =======================================
    // scenarios
    initial begin
        void'($urandom(32'h25ae));
        {reset_n, energy_present, link_up, autoneg_en, chip_power_down_pin_n} = 5'b01001;
        rx = '0;
        rx_frame_crc = 16'h0000;
        node_addr = {$urandom, 16'($urandom)} & 48'h7f7f_7f7f_7f7f;
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        gchk(6'h37, 6'h3f);
        pins(1'b1, 1'b0);
        rdx(8'hd4, 16'h0000);
        e = 16'($urandom) & 16'h008f;
        wr(8'h2a, e);
        rdx(8'h2a, e);
        $display("test reset done");
        wr(8'hd6, 16'h0101);
        wr(8'h90, 16'h0004);
        energy_present = 1'b0;
        wr(8'hd4, 16'h0181);
        wt(0, 1'b0);
        gchk(6'h04, 6'h3f);
        energy_present = 1'b1;
        wt(0, 1'b1);
        pins(1'b0, 1'b1);
        rdx(8'h92, 16'h0004);
        rdx(8'hd4, 16'h0181);
        wr(8'h92, 16'h0004);
        pins(1'b1, 1'b0);
        wr(8'hd4, 16'h01c1);
        energy_present = 1'b0;
        wt(0, 1'b0);
        energy_present = 1'b1;
        wt(0, 1'b1);
        rdx(8'hd4, 16'h01c0);
        wr(8'h92, 16'h003c);
        wr(8'hd4, 16'h0001);
        energy_present = 1'b0;
        wt(0, 1'b0);
        energy_present = 1'b1;
        wt(1, 1'b0);
        gchk(6'h04, 6'h3f);
        pmwe_host_model_i.lat = $urandom_range(1, 40);
        pmwe_host_model_i.auto_wake = 1'b1;
        wt(0, 1'b1);
        wr(8'h92, 16'h003c);
        $display("test energy detect done");
        wr(8'hd4, 16'h0002);
        gchk(6'h00, 6'h33);
        wr(8'hd4, 16'h0000);
        gchk(6'h00, 6'h33);
        pmwe_host_model_i.rd(8'h26, 1'b0);
        gchk(6'h33, 6'h33);
        rdx(8'hd4, 16'h0000);
        $display("test soft power down done");
        energy_present = 1'b0;
        wr(8'hf6, 16'h0400);
        wr(8'hd4, 16'h0003);
        gchk(6'h33, 6'h3b);
        wr(8'hd4, 16'h0000);
        autoneg_en = 1'b1;
        wr(8'hd4, 16'h0003);
        gchk(6'h3b, 6'h3b);
        energy_present = 1'b1;
        gchk(6'h33, 6'h3b);
        wr(8'hd4, 16'h0000);
        wr(8'hf6, 16'h0000);
        gchk(6'h33, 6'h3b);
        $display("test power saving done");
        wr(8'h92, 16'h003c);
        wr(8'h90, 16'h0008);
        link_up = 1'b1;
        pins(1'b0, 1'b0);
        rdx(8'h92, 16'h0008);
        wr(8'h92, 16'h0008);
        pins(1'b1, 1'b0);
        $display("test link up done");
        // wake frames 0-3, then pattern: good, 15 copies, bad crc, scanning off
        for (int k = 0; k < 8; k++) begin
            crc = 16'($urandom);
            e = (k < 4) ? 16'h0020 : ((k == 4) ? 16'h0010 : 16'h0000);
            wr(8'h2a, (k < 4) ? (16'h0001 << k) : {8'h00, k != 7, 7'h00});
            if (k < 4) wr(8'h30 + 8'(k << 4), crc);
            wr(8'h90, (k < 4 && k[0]) ? 16'h0010 : 16'h0030);
            wr(8'hd4, {7'h00, k < 4 && k[0], 8'h00});
            frame((k < 4) ? 0 : 16 - (k == 5), k != 6, crc);
            pins((k < 4) ? k[0] : k != 4, k < 4 && k[0]);
            rdx(8'h92, e);
            wr(8'h92, 16'h003c);
        end
        $display("test wake frames done");
        wr(8'hd4, 16'h0100);
        chip_power_down_pin_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        check("chip_reset_n", 16'h0000, 16'(chip_reset_n));
        chip_power_down_pin_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        rdx(8'hd4, 16'h0000);
        $display("test power-down pin done");
        final_report;
    end
endmodule
